// *** rtl/dai_top.v ***
// dual channel converter digital output interface
// Functional notes
// - both channels sample on one rising edge
// - pick high selects external reference voltages
// - open pick means external; low means internal
// - span choice ignored with external reference
// - external reference change seen after 8-10 samples
// - over-range flag high when sample reaches the top bound or falls below the bottom bound
// - flag delayed through same pipeline as word
// - tristate control high raises that channel's data_oe_n_a or data_oe_n_b; channel words stay driven
// - output words are straight offset binary
// - two parallel words, one update per sample
`timescale 1ns/100ps
`include "dai_consts.vh"
module dai_top #(
  parameter DATA_W  = `DAI_DATA_W,
  parameter DEPTH   = `DAI_PIPE_DEPTH,
  parameter REF_LAT = `DAI_REF_LAT_DEF
) (
  input  wire              ref_clk,
  input  wire              arst_n,
  input  wire              smp_en,
  input  wire              ref_source_pick,
  input  wire              ref_pick_open,
  input  wire              span_sel,
  input  wire [DATA_W:0]   top_reference,
  input  wire [DATA_W:0]   bottom_reference,
  input  wire [DATA_W:0]   samp_a,
  input  wire [DATA_W:0]   samp_b,
  input  wire              out_off_a,
  input  wire              out_off_b,
  output wire [DATA_W-1:0] data_a,
  output wire              over_range_flag_a,
  output wire              data_oe_n_a,
  output wire [DATA_W-1:0] data_b,
  output wire              over_range_flag_b,
  output wire              data_oe_n_b,
  output wire              ext_ref_active,
  output wire [DATA_W:0]   common_mode_level,
  output wire              data_valid
);
  // samples are signed, span centred on zero; references are bounds
  localparam [DATA_W:0] SPAN2_HALF = {1'b0, 1'b1, {(DATA_W-1){1'b0}}};
  localparam [DATA_W:0] SPAN3_HALF = {1'b0, 2'b11, {(DATA_W-2){1'b0}}};

  // reference pick: open or high means external
  wire ext_sel = ref_pick_open | (ref_source_pick == `DAI_REF_EXT);
  assign ext_ref_active = ext_sel;

  // external reference latency line
  reg [DATA_W:0] top_dly_reg [0:REF_LAT-1];
  reg [DATA_W:0] bot_dly_reg [0:REF_LAT-1];
  integer k;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (k = 0; k < REF_LAT; k = k + 1) begin
        top_dly_reg[k] <= SPAN2_HALF;
        bot_dly_reg[k] <= {(DATA_W+1){1'b0}} - SPAN2_HALF;
      end
    end else if (smp_en) begin
      top_dly_reg[0] <= top_reference;
      bot_dly_reg[0] <= bottom_reference;
      for (k = 1; k < REF_LAT; k = k + 1) begin
        top_dly_reg[k] <= top_dly_reg[k-1];
        bot_dly_reg[k] <= bot_dly_reg[k-1];
      end
    end
  end

  // span choice only under internal reference
  reg [DATA_W:0] hi_lim;
  reg [DATA_W:0] lo_lim;
  always @* begin
    if (ext_sel) begin
      hi_lim = top_dly_reg[REF_LAT-1];
      lo_lim = bot_dly_reg[REF_LAT-1];
    end else if (span_sel == `DAI_SPAN_3V) begin
      hi_lim = SPAN3_HALF;
      lo_lim = {(DATA_W+1){1'b0}} - SPAN3_HALF;
    end else begin
      hi_lim = SPAN2_HALF;
      lo_lim = {(DATA_W+1){1'b0}} - SPAN2_HALF;
    end
  end

  // signed midpoint of the active limits, halved by dropping the lsb
  wire signed [DATA_W+1:0] mid_sum = $signed({hi_lim[DATA_W], hi_lim}) + $signed({lo_lim[DATA_W], lo_lim});
  assign common_mode_level = mid_sum[DATA_W+1:1];

  // map a signed sample onto offset binary, clamp and flag
  function [DATA_W:0] encode;
    input [DATA_W:0] s;
    input [DATA_W:0] hi;
    input [DATA_W:0] lo;
    reg signed [DATA_W+1:0] v;
    reg signed [DATA_W+1:0] h;
    reg signed [DATA_W+1:0] l;
    reg signed [DATA_W+1:0] d;
    reg        [2*DATA_W+1:0] num;
    reg        [2*DATA_W+1:0] den;
    reg        [2*DATA_W+1:0] quo;
    begin
      v = $signed({s[DATA_W], s});
      h = $signed({hi[DATA_W], hi});
      l = $signed({lo[DATA_W], lo});
      if (v >= h)
        encode = {1'b1, `DAI_CODE_MAX};
      else if (v < l)
        encode = {1'b1, `DAI_CODE_ZERO};
      else begin
        d   = v - l; // wide quotient avoids overflow of the scaled offset
        num = {d, {DATA_W{1'b0}}};
        den = {{DATA_W{1'b0}}, h - l};
        quo = num / den;
        encode = {1'b0, quo[DATA_W-1:0]};
      end
    end
  endfunction

  wire [DATA_W:0] enc_a = encode(samp_a, hi_lim, lo_lim);
  wire [DATA_W:0] enc_b = encode(samp_b, hi_lim, lo_lim);

  // both channels on the same enable edge
  dai_pipe #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_pipe_a (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .smp_en   (smp_en),
    .word_in  (enc_a[DATA_W-1:0]),
    .flag_in  (enc_a[DATA_W]),
    .word_out (data_a),
    .flag_out (over_range_flag_a)
  );
  dai_pipe #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_pipe_b (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .smp_en   (smp_en),
    .word_in  (enc_b[DATA_W-1:0]),
    .flag_in  (enc_b[DATA_W]),
    .word_out (data_b),
    .flag_out (over_range_flag_b)
  );

  // one-cycle strobe after each output update
  reg valid_reg;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      valid_reg <= 1'b0;
    else
      valid_reg <= smp_en;
  end
  assign data_valid = valid_reg;

  // output enables, low drives the pins
  assign data_oe_n_a = out_off_a;
  assign data_oe_n_b = out_off_b;
endmodule // dai_top

// *** rtl/dai_consts.vh ***
// constants for the dual converter output interface
`ifndef DAI_CONSTS_VH
`define DAI_CONSTS_VH
`define DAI_DATA_W        12
`define DAI_PIPE_DEPTH    6
`define DAI_REF_LAT_MIN   8
`define DAI_REF_LAT_MAX   10
`define DAI_REF_LAT_DEF   9
`define DAI_REF_EXT       1'b1
`define DAI_REF_INT       1'b0
`define DAI_SPAN_2V       1'b0
`define DAI_SPAN_3V       1'b1
`define DAI_CODE_ZERO     12'h000
`define DAI_CODE_MID      12'h800
`define DAI_CODE_MAX      12'hfff
`endif

// *** rtl/dai_pipe.v ***
// fixed-depth delay line for one channel word and flag
`timescale 1ns/100ps
`include "dai_consts.vh"
module dai_pipe #(
  parameter DATA_W = `DAI_DATA_W,
  parameter DEPTH  = `DAI_PIPE_DEPTH
) (
  input  wire              ref_clk,
  input  wire              arst_n,
  input  wire              smp_en,
  input  wire [DATA_W-1:0] word_in,
  input  wire              flag_in,
  output wire [DATA_W-1:0] word_out,
  output wire              flag_out
);
  reg [DATA_W-1:0] word_reg [0:DEPTH-1];
  reg              flag_reg [0:DEPTH-1];
  integer i;

  // word and flag shift together per sample
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        word_reg[i] <= `DAI_CODE_MID;
        flag_reg[i] <= 1'b0;
      end
    end else if (smp_en) begin
      word_reg[0] <= word_in;
      flag_reg[0] <= flag_in;
      for (i = 1; i < DEPTH; i = i + 1) begin
        word_reg[i] <= word_reg[i-1];
        flag_reg[i] <= flag_reg[i-1];
      end
    end
  end

  assign word_out = word_reg[DEPTH-1];
  assign flag_out = flag_reg[DEPTH-1];
endmodule // dai_pipe

// *** test/dai_chk_asserts.sv ***
// assertions on the dual converter output pins
`timescale 1ns/100ps
module dai_chk #(
  parameter DATA_W = 12
) (
  input wire              ref_clk,
  input wire              arst_n,
  input wire              smp_en,
  input wire              ref_source_pick,
  input wire              ref_pick_open,
  input wire              out_off_a,
  input wire              out_off_b,
  input wire [DATA_W:0]   samp_a,
  input wire [DATA_W:0]   samp_b,
  input wire [DATA_W-1:0] data_a,
  input wire [DATA_W-1:0] data_b,
  input wire              over_range_flag_a,
  input wire              over_range_flag_b,
  input wire              data_oe_n_a,
  input wire              data_oe_n_b,
  input wire              ext_ref_active,
  input wire              data_valid
);
  // one clock, reset aborts every check
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_oe_a_follow: assert property (data_oe_n_a == out_off_a)
    else $error("oe a wrong");
  chk_oe_b_follow: assert property (data_oe_n_b == out_off_b)
    else $error("oe b wrong");
  chk_ref_pick: assert property (ext_ref_active == (ref_source_pick | ref_pick_open))
    else $error("reference pick wrong");
  chk_valid_pulse: assert property (1 |=> data_valid == $past(smp_en))
    else $error("valid pulse wrong");
  chk_hold_word: assert property (!smp_en |=> $stable(data_a) && $stable(data_b))
    else $error("word moved without sample");
  chk_flag_code_a: assert property (over_range_flag_a |-> data_a == 12'h000 || data_a == 12'hfff)
    else $error("flag a without end code");
  chk_flag_code_b: assert property (over_range_flag_b |-> data_b == 12'h000 || data_b == 12'hfff)
    else $error("flag b without end code");
  chk_chan_pair: assert property ((smp_en && samp_a == samp_b) [*8] |->
    data_a == data_b && over_range_flag_a == over_range_flag_b)
    else $error("channels not aligned");
  cover property (over_range_flag_a);
  cover property (data_oe_n_a);
  cover property ($fell(smp_en));
endmodule // dai_chk
bind dai_top dai_chk #(.DATA_W(DATA_W)) u_chk (.*);

// *** test/dai_capture.sv ***
// capture logic latching both channel words
`timescale 1ns/100ps
module dai_capture (
  input  wire        ref_clk,
  input  wire        data_valid,
  input  wire [11:0] data_a,
  input  wire [11:0] data_b,
  output reg  [11:0] cap_a,
  output reg  [11:0] cap_b
);
  // latch each new word as twos complement
  always @(posedge ref_clk) if (data_valid) begin
    cap_a <= {~data_a[11], data_a[10:0]};
    cap_b <= {~data_b[11], data_b[10:0]};
  end
endmodule // dai_capture

// *** test/testbench.sv ***
// self-checking bench for the dual converter output interface
`timescale 1ns/100ps
module testbench;
  reg         ref_clk = 0, arst_n = 0, smp_en = 1, pick = 0, open = 0, span = 0, off_a = 0, off_b = 0;
  reg  [12:0] hi = 13'h03e8, lo = 13'h1c18, sa = 13'h0000, sb = 13'h0000;
  wire [11:0] da, db, ca, cb;
  wire [12:0] cm;
  wire        fa, fb, oa, ob, ext, dv;
  integer     miscompares = 0, compares = 0, cyc = 0;
  dai_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .smp_en(smp_en), .ref_source_pick(pick), .ref_pick_open(open),
    .span_sel(span), .top_reference(hi), .bottom_reference(lo), .samp_a(sa), .samp_b(sb), .out_off_a(off_a),
    .out_off_b(off_b), .data_a(da), .over_range_flag_a(fa), .data_oe_n_a(oa), .data_b(db),
    .over_range_flag_b(fb), .data_oe_n_b(ob), .ext_ref_active(ext), .common_mode_level(cm), .data_valid(dv));
  dai_capture cap (.ref_clk(ref_clk), .data_valid(dv), .data_a(da), .data_b(db), .cap_a(ca), .cap_b(cb));
  // clock and hang guard
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  task cmp(input string n, input [12:0] e, input [12:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // apply one sample pair, let it settle, check word, flag and capture
  task conv(input [12:0] s_a, input [12:0] s_b, input [12:0] e_a, input [12:0] e_b);
    begin
      @(posedge ref_clk) #1 sa = s_a;
      sb = s_b;
      repeat (20) @(posedge ref_clk);
      #1 cmp("chan a", e_a, {fa, da});
      cmp("chan b", e_b, {fb, db});
      cmp("capture a", {1'b0, ~e_a[11], e_a[10:0]}, {1'b0, ca});
      cmp("capture b", {1'b0, ~e_b[11], e_b[10:0]}, {1'b0, cb});
    end
  endtask
  task t_codes;
    begin
      conv(13'h0000, 13'h07ff, 13'h0800, 13'h0fff);
      conv(13'h1800, 13'h0400, 13'h0000, 13'h0c00);
      conv(13'h0800, 13'h17ff, 13'h1fff, 13'h1000);
      $display("codes done");
    end
  endtask
  task t_span;
    begin
      span = 1;
      conv(13'h09c4, 13'h09c4, 13'h0e82, 13'h0e82);
      pick = 1;
      conv(13'h01f4, 13'h03e8, 13'h0c00, 13'h1fff);
      pick = 0;
      open = 1;
      conv(13'h01f4, 13'h01f4, 13'h0c00, 13'h0c00);
      cmp("ext ref", 13'h0001, {12'h000, ext});
      $display("span done");
    end
  endtask
  // step the external bottom bound, old result before, new after the latency
  task t_ref_lat;
    begin
      @(posedge ref_clk) #1 lo = 13'h1830;
      repeat (12) @(posedge ref_clk);
      #1 cmp("ref old a", 13'h0c00, {fa, da});
      repeat (4) @(posedge ref_clk);
      #1 cmp("ref new a", 13'h0d55, {fa, da});
      cmp("mid level", 13'h1e0c, cm);
      lo = 13'h1c18;
      repeat (20) @(posedge ref_clk);
      #1 cmp("ref back a", 13'h0c00, {fa, da});
      $display("ref latency done");
    end
  endtask
  task t_oe;
    begin
      off_a = 1;
      smp_en = 0;
      sa = 13'h0123;
      repeat (4) @(posedge ref_clk);
      #1 cmp("oe a", 13'h0001, {12'h000, oa});
      cmp("oe b", 13'h0000, {12'h000, ob});
      cmp("held a", 13'h0c00, {fa, da});
      off_a = 0;
      smp_en = 1;
      $display("oe done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 arst_n = 1;
    t_codes;
    t_span;
    t_ref_lat;
    t_oe;
    tally_and_finish;
  end
endmodule // testbench
